// *** hw/cag_pkg.sv ***
// shared constants for the add instruction group execution unit
package cag_pkg;
  // opcodes
  localparam logic [7:0] OP_ADD_B_INTO_A = 8'h1b;
  localparam logic [7:0] OP_ADD_B_TO_INDEX = 8'h3a;
  localparam logic [7:0] OP_PREFIX_Y = 8'h18;
  localparam logic [7:0] OP_ADC_A_IMM = 8'h89;
  localparam logic [7:0] OP_ADC_A_DIR = 8'h99;
  localparam logic [7:0] OP_ADC_A_EXT = 8'hb9;
  localparam logic [7:0] OP_ADC_A_IDX = 8'ha9;
  localparam logic [7:0] OP_ADC_B_IMM = 8'hc9;
  localparam logic [7:0] OP_ADC_B_DIR = 8'hd9;
  localparam logic [7:0] OP_ADC_B_EXT = 8'hf9;
  localparam logic [7:0] OP_ADC_B_IDX = 8'he9;
  localparam logic [7:0] OP_ADD_A_IMM = 8'h8b;
  localparam logic [7:0] OP_ADD_A_DIR = 8'h9b;
  localparam logic [7:0] OP_ADD_A_EXT = 8'hbb;
  localparam logic [7:0] OP_ADD_A_IDX = 8'hab;
  localparam logic [7:0] OP_ADD_B_IMM = 8'hcb;
  localparam logic [7:0] OP_ADD_B_DIR = 8'hdb;
  localparam logic [7:0] OP_ADD_B_EXT = 8'hfb;
  localparam logic [7:0] OP_ADD_B_IDX = 8'heb;
  // dummy read address
  localparam logic [15:0] DUMMY_ADDR = 16'hffff;
  // condition flag bit positions
  localparam int FLAG_STOP = 7;
  localparam int FLAG_XMASK = 6;
  localparam int FLAG_HALF = 5;
  localparam int FLAG_IMASK = 4;
  localparam int FLAG_NEG = 3;
  localparam int FLAG_ZERO = 2;
  localparam int FLAG_OVF = 1;
  localparam int FLAG_CARRY = 0;
  // reset values
  localparam logic [15:0] RESET_PC = 16'h0000;
  localparam logic [7:0] RESET_FLAGS = 8'hd0;
  // sequencer states
  typedef enum logic [3:0] {
    ST_FETCH, ST_PREFIX, ST_INH, ST_DUMMY, ST_ADDR_HI, ST_ADDR_LO,
    ST_OFFSET, ST_IDX_DUMMY, ST_OPERAND
  } cag_state_t;
  // addressing modes
  typedef enum logic [2:0] {MODE_IMM, MODE_DIR, MODE_EXT, MODE_IDX_X, MODE_IDX_Y} cag_mode_t;
endpackage

// *** hw/cag_adder.sv ***
// 8-bit adder with condition flag equations
`timescale 1ns/100ps
module cag_adder (
  // operands
  input wire logic [7:0] opnd_x,
  input wire logic [7:0] opnd_m,
  input wire logic carry_in,
  // result and flags
  output logic [7:0] sum,
  output logic half,
  output logic neg,
  output logic zero,
  output logic ovf,
  output logic carry
);
  // flags follow the boolean forms on operand and result bits
  always_comb begin
    sum = opnd_x + opnd_m + {7'h00, carry_in};
    half = (opnd_x[3] & opnd_m[3]) | (opnd_m[3] & ~sum[3]) | (~sum[3] & opnd_x[3]);
    neg = sum[7];
    zero = (sum == 8'h00);
    ovf = (opnd_x[7] & opnd_m[7] & ~sum[7]) | (~opnd_x[7] & ~opnd_m[7] & sum[7]);
    carry = (opnd_x[7] & opnd_m[7]) | (opnd_m[7] & ~sum[7]) | (~sum[7] & opnd_x[7]);
  end
endmodule // cag_adder

// *** hw/cag_core.sv ***
// execution sequencer for the add instruction group
`timescale 1ns/100ps
module cag_core (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // memory bus, reads only
  input wire logic [7:0] read_data,
  output logic [15:0] addr,
  output logic read_write,
  output logic fetch_strobe,
  // architectural state
  output logic [7:0] accumulator_a,
  output logic [7:0] accumulator_b,
  output logic [15:0] index_x,
  output logic [15:0] index_y,
  output logic [7:0] condition_flags_register,
  output logic illegal_op
);
  // reset release synchroniser
  logic rst_meta, rst_sync;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  cag_pkg::cag_state_t state, next_state;
  cag_pkg::cag_mode_t mode, next_mode;
  logic [15:0] pc, next_pc;
  logic [15:0] next_addr;
  logic [7:0] next_acc_a, next_acc_b, next_flags, addr_hi, next_addr_hi;
  logic [15:0] next_index_x, next_index_y;
  logic use_carry, next_use_carry, to_b, next_to_b, next_fetch, next_illegal;
  logic [15:0] eff, next_eff;
  logic [7:0] sum;
  logic f_half, f_neg, f_zero, f_ovf, f_carry;

  // operand is read_data in the operand cycle; accumulator chosen by decode
  cag_adder u_adder (
    .opnd_x(state == cag_pkg::ST_INH ? accumulator_a : (to_b ? accumulator_b : accumulator_a)),
    .opnd_m(state == cag_pkg::ST_INH ? accumulator_b : read_data),
    .carry_in(use_carry & condition_flags_register[cag_pkg::FLAG_CARRY]),
    .sum(sum),
    .half(f_half),
    .neg(f_neg),
    .zero(f_zero),
    .ovf(f_ovf),
    .carry(f_carry)
  );

  // writes flags of an 8-bit add, masks and stop bit kept as they were
  function automatic logic [7:0] merge_flags(input logic [7:0] old, input logic h,
      input logic n, input logic z, input logic v, input logic c);
    logic [7:0] f;
    f = old;
    f[cag_pkg::FLAG_HALF] = h;
    f[cag_pkg::FLAG_NEG] = n;
    f[cag_pkg::FLAG_ZERO] = z;
    f[cag_pkg::FLAG_OVF] = v;
    f[cag_pkg::FLAG_CARRY] = c;
    return f;
  endfunction

  // next-state decode and execution
  always_comb begin
    next_state = state;
    next_mode = mode;
    next_pc = pc;
    next_addr = addr;
    next_acc_a = accumulator_a;
    next_acc_b = accumulator_b;
    next_index_x = index_x;
    next_index_y = index_y;
    next_flags = condition_flags_register;
    next_use_carry = use_carry;
    next_to_b = to_b;
    next_eff = eff;
    next_addr_hi = addr_hi;
    next_fetch = 1'b0;
    next_illegal = 1'b0;
    case (state)
      cag_pkg::ST_FETCH: begin
        // addr presents the opcode address this cycle
        next_pc = pc + 16'h0001;
        next_addr = pc + 16'h0001;
        next_use_carry = ~read_data[1]; // x9 is add with carry, xb plain
        next_to_b = read_data[6];
        next_mode = cag_pkg::MODE_IDX_X;
        next_state = cag_pkg::ST_OPERAND;
        if (read_data == cag_pkg::OP_ADD_B_INTO_A) begin
          next_state = cag_pkg::ST_INH;
        end else if (read_data == cag_pkg::OP_ADD_B_TO_INDEX) begin
          next_state = cag_pkg::ST_DUMMY;
        end else if (read_data == cag_pkg::OP_PREFIX_Y) begin
          next_state = cag_pkg::ST_PREFIX;
        end else if (read_data[3:0] == 4'h9 || read_data[3:0] == 4'hb) begin
          if (read_data[7] == 1'b1 && read_data[5:4] == 2'b00) begin
            next_mode = cag_pkg::MODE_IMM;
            next_state = cag_pkg::ST_OPERAND;
          end else if (read_data[7] == 1'b1 && read_data[5:4] == 2'b01) begin
            next_mode = cag_pkg::MODE_DIR;
            next_state = cag_pkg::ST_ADDR_LO;
          end else if (read_data[7] == 1'b1 && read_data[5:4] == 2'b11) begin
            next_mode = cag_pkg::MODE_EXT;
            next_state = cag_pkg::ST_ADDR_HI;
          end else if (read_data[7] == 1'b1) begin
            next_state = cag_pkg::ST_OFFSET;
          end else begin
            next_illegal = 1'b1;
            next_state = cag_pkg::ST_FETCH;
            next_fetch = 1'b1;
          end
        end else begin
          // nothing adds accumulator a to an index, treat as unknown
          next_illegal = 1'b1;
          next_state = cag_pkg::ST_FETCH;
          next_fetch = 1'b1;
        end
      end
      cag_pkg::ST_PREFIX: begin
        next_pc = pc + 16'h0001;
        next_addr = pc + 16'h0001;
        next_to_b = read_data[6];
        next_use_carry = ~read_data[1];
        if (read_data == cag_pkg::OP_ADD_B_TO_INDEX) begin
          next_mode = cag_pkg::MODE_IDX_Y;
          next_state = cag_pkg::ST_INH; // third cycle reads next byte
        end else if (read_data == cag_pkg::OP_ADC_A_IDX || read_data == cag_pkg::OP_ADC_B_IDX ||
            read_data == cag_pkg::OP_ADD_A_IDX || read_data == cag_pkg::OP_ADD_B_IDX) begin
          next_mode = cag_pkg::MODE_IDX_Y;
          next_state = cag_pkg::ST_OFFSET;
        end else begin
          next_illegal = 1'b1;
          next_state = cag_pkg::ST_FETCH;
          next_fetch = 1'b1;
        end
      end
      cag_pkg::ST_INH: begin
        if (mode == cag_pkg::MODE_IDX_Y) begin
          // next byte read, pc held, then dummy
          next_addr = cag_pkg::DUMMY_ADDR;
          next_state = cag_pkg::ST_DUMMY;
        end else begin
          next_acc_a = sum;
          next_flags = merge_flags(condition_flags_register, f_half, f_neg, f_zero,
              f_ovf, f_carry);
          next_state = cag_pkg::ST_FETCH;
          next_fetch = 1'b1;
        end
      end
      cag_pkg::ST_DUMMY: begin
        if (addr != cag_pkg::DUMMY_ADDR) begin
          // x form: second cycle reads op+1, go to ffff
          next_addr = cag_pkg::DUMMY_ADDR;
        end else begin
          if (mode == cag_pkg::MODE_IDX_Y) begin
            next_index_y = index_y + {8'h00, accumulator_b};
          end else begin
            next_index_x = index_x + {8'h00, accumulator_b};
          end
          next_addr = pc;
          next_state = cag_pkg::ST_FETCH;
          next_fetch = 1'b1;
        end
      end
      cag_pkg::ST_ADDR_HI: begin
        next_addr_hi = read_data;
        next_pc = pc + 16'h0001;
        next_addr = pc + 16'h0001;
        next_state = cag_pkg::ST_ADDR_LO;
      end
      cag_pkg::ST_ADDR_LO: begin
        next_pc = pc + 16'h0001;
        next_addr = (mode == cag_pkg::MODE_DIR) ? {8'h00, read_data} : {addr_hi, read_data};
        next_state = cag_pkg::ST_OPERAND;
      end
      cag_pkg::ST_OFFSET: begin
        next_pc = pc + 16'h0001;
        next_eff = ((mode == cag_pkg::MODE_IDX_Y) ? index_y : index_x) + {8'h00, read_data};
        next_addr = cag_pkg::DUMMY_ADDR;
        next_state = cag_pkg::ST_IDX_DUMMY;
      end
      cag_pkg::ST_IDX_DUMMY: begin
        next_addr = eff;
        next_state = cag_pkg::ST_OPERAND;
      end
      cag_pkg::ST_OPERAND: begin
        if (mode == cag_pkg::MODE_IMM) begin
          next_pc = pc + 16'h0001;
        end
        if (to_b) begin
          next_acc_b = sum;
        end else begin
          next_acc_a = sum;
        end
        next_flags = merge_flags(condition_flags_register, f_half, f_neg, f_zero, f_ovf, f_carry);
        next_addr = (mode == cag_pkg::MODE_IMM) ? pc + 16'h0001 : pc;
        next_state = cag_pkg::ST_FETCH;
        next_fetch = 1'b1;
      end
      default: begin
        next_state = cag_pkg::ST_FETCH;
      end
    endcase
    if (next_state == cag_pkg::ST_FETCH && state == cag_pkg::ST_INH) begin
      next_addr = pc; // inherent add b into a: op+1 was already the next opcode
    end
  end

  // all state registered on every edge; bus is always a read
  always_ff @(posedge clock or negedge rst_sync) begin
    if (!rst_sync) begin
      state <= cag_pkg::ST_FETCH;
      mode <= cag_pkg::MODE_IMM;
      pc <= cag_pkg::RESET_PC;
      addr <= cag_pkg::RESET_PC;
      read_write <= 1'b1;
      fetch_strobe <= 1'b1;
      accumulator_a <= 8'h00;
      accumulator_b <= 8'h00;
      index_x <= 16'h0000;
      index_y <= 16'h0000;
      condition_flags_register <= cag_pkg::RESET_FLAGS;
      use_carry <= 1'b0;
      to_b <= 1'b0;
      eff <= 16'h0000;
      addr_hi <= 8'h00;
      illegal_op <= 1'b0;
    end else begin
      state <= next_state;
      mode <= next_mode;
      pc <= next_pc;
      addr <= next_addr;
      read_write <= 1'b1;
      fetch_strobe <= next_fetch;
      accumulator_a <= next_acc_a;
      accumulator_b <= next_acc_b;
      index_x <= next_index_x;
      index_y <= next_index_y;
      condition_flags_register <= next_flags;
      use_carry <= next_use_carry;
      to_b <= next_to_b;
      eff <= next_eff;
      addr_hi <= next_addr_hi;
      illegal_op <= next_illegal;
    end
  end
endmodule // cag_core

// *** sim/cag_core_asserts.sv ***
// port-level checks for the add group core, bound into cag_core
`timescale 1ns/100ps
module cag_core_chk (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // memory bus
  input wire logic [7:0] read_data,
  input wire logic [15:0] addr,
  input wire logic read_write,
  input wire logic fetch_strobe,
  // architectural state
  input wire logic [7:0] accumulator_a,
  input wire logic [7:0] accumulator_b,
  input wire logic [15:0] index_x,
  input wire logic [15:0] index_y,
  input wire logic [7:0] condition_flags_register
);
  // core leaves reset two edges after rstn rises, so checks wait as long
  logic rstn_q1, rstn_q2;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rstn_q1 <= 1'b0;
      rstn_q2 <= 1'b0;
    end else begin
      rstn_q1 <= 1'b1;
      rstn_q2 <= rstn_q1;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn_q2);
  // opcode checks start on fetch_strobe, which operand bytes never raise; read and mask checks hold every cycle
  always_read_a: assert property (read_write)
    else $error("bus cycle is not a read");
  b_into_a_a: assert property (fetch_strobe && read_data == 8'h1b |=> !fetch_strobe ##1
    fetch_strobe && accumulator_a == $past(accumulator_a, 2) + $past(accumulator_b, 2))
    else $error("add b into a wrong sum or length");
  b_to_x_a: assert property (fetch_strobe && read_data == 8'h3a |=> ##1 addr == 16'hffff
    ##1 fetch_strobe && index_x == $past(index_x, 3) + {8'h00, $past(accumulator_b, 3)}
    && condition_flags_register == $past(condition_flags_register, 3))
    else $error("add b to index x wrong");
  b_to_y_a: assert property (fetch_strobe && read_data == 8'h18 ##1 read_data == 8'h3a
    |=> ##1 addr == 16'hffff ##1 fetch_strobe
    && index_y == $past(index_y, 4) + {8'h00, $past(accumulator_b, 4)}
    && condition_flags_register == $past(condition_flags_register, 4))
    else $error("add b to index y wrong");
  imm_len_a: assert property (fetch_strobe && read_data inside {8'h89, 8'hc9, 8'h8b, 8'hcb}
    |=> !fetch_strobe ##1 fetch_strobe && addr == $past(addr, 2) + 16'h0002)
    else $error("immediate add wrong length");
  dir_addr_a: assert property (fetch_strobe && read_data inside {8'h99, 8'hd9, 8'h9b, 8'hdb}
    ##1 1'b1 |=> addr == {8'h00, $past(read_data)} ##1 fetch_strobe)
    else $error("direct operand address wrong");
  idx_addr_a: assert property (fetch_strobe && read_data inside {8'ha9, 8'he9, 8'hab, 8'heb}
    |=> ##1 addr == 16'hffff ##1 addr == index_x + {8'h00, $past(read_data, 2)} ##1 fetch_strobe)
    else $error("indexed operand sequence wrong");
  masks_kept_a: assert property ($stable({condition_flags_register[7:6],
    condition_flags_register[4]})) else $error("mask bit changed");
  // main scenarios reached
  cover property (fetch_strobe && read_data == 8'h18 ##1 read_data == 8'h3a);
  cover property (fetch_strobe && read_data == 8'hab);
  cover property (fetch_strobe && read_data == 8'h1b);
endmodule // cag_core_chk

bind cag_core cag_core_chk chk (.clock(clock), .rstn(rstn), .read_data(read_data),
  .addr(addr), .read_write(read_write), .fetch_strobe(fetch_strobe),
  .accumulator_a(accumulator_a), .accumulator_b(accumulator_b), .index_x(index_x),
  .index_y(index_y), .condition_flags_register(condition_flags_register));

// *** sim/cag_mem.sv ***
// zero-latency byte memory answering every core read
`timescale 1ns/100ps
module cag_mem (
  // bus from the core
  input wire logic [15:0] addr,
  input wire logic read_write,
  // data back
  output logic [7:0] read_data
);
  logic [7:0] ram [65536];
  // no wait states; garbage when not a read so nothing is trusted there
  assign read_data = read_write ? ram[addr] : ~ram[addr];
endmodule // cag_mem

// *** sim/cpu_add_instruction_group_tb.sv ***
// self-checking bench for the add instruction group core
`timescale 1ns/100ps
module cpu_add_instruction_group_tb;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] read_data, accumulator_a, accumulator_b, condition_flags_register;
  logic [15:0] addr, index_x, index_y, pc;
  logic read_write, fetch_strobe, illegal_op;
  int n_errors = 0;
  int n_tests = 0;
  // 25 MHz clock
  always #20 clock = ~clock;
  cag_core dut (.clock(clock), .rstn(rstn), .read_data(read_data), .addr(addr),
    .read_write(read_write), .fetch_strobe(fetch_strobe), .accumulator_a(accumulator_a),
    .accumulator_b(accumulator_b), .index_x(index_x), .index_y(index_y),
    .condition_flags_register(condition_flags_register), .illegal_op(illegal_op));
  cag_mem mem (.addr(addr), .read_write(read_write), .read_data(read_data));
  // verdict and end of run
  task stop_test;
    $display("errors %0d of %0d checks", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task put(input logic [7:0] b);
    mem.ram[pc] = b;
    pc++;
  endtask
  // reset, then sync on the skipped filler byte at 0000
  task start;
    int n;
    pc = 16'h0001;
    @(posedge clock);
    rstn <= 1'b0;
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (illegal_op !== 1'b1 && n < 10);
    if (n >= 10) begin
      n_errors++;
      stop_test;
    end
    check(addr, 16'h0001);
  endtask
  // count cycles up to the next opcode fetch and check its address
  task step(input int cyc, input int len);
    int n;
    n = 0;
    pc = pc + 16'(len);
    do begin
      @(negedge clock);
      n++;
    end while (fetch_strobe !== 1'b1 && n < 9);
    if (n >= 9) begin
      n_errors++;
      stop_test;
    end
    check(16'(n), 16'(cyc));
    check(addr, pc);
  endtask
  // every memory add opcode in every mode, each adding one
  task all_codes;
    logic [3:0] hn [8];
    logic [7:0] op;
    int md [20];
    int cyc [5];
    hn = '{4'h8, 4'h9, 4'hb, 4'ha, 4'hc, 4'hd, 4'hf, 4'he};
    cyc = '{2, 3, 4, 4, 5};
    pc = 16'h0001;
    mem.ram[16'h0040] = 8'h01;
    for (int i = 0; i < 20; i++) begin
      md[i] = (i < 16) ? i % 4 : 4;
      op = {hn[i % 8], (i < 8) ? 4'h9 : 4'hb};
      if (i >= 16) op = {(i < 18) ? 4'ha : 4'he, (i % 2) ? 4'hb : 4'h9};
      if (md[i] == 4) put(8'h18);
      put(op);
      if (md[i] == 2) put(8'h00);
      put((md[i] == 0) ? 8'h01 : 8'h40);
    end
    start;
    for (int i = 0; i < 20; i++) step(cyc[md[i]], (md[i] == 2 || md[i] == 4) ? 3 : 2);
    check({8'h00, accumulator_a}, 16'h000a);
    check({8'h00, accumulator_b}, 16'h000a);
  endtask
  // immediate and inherent adds driving every flag both ways
  task flag_table;
    logic [7:0] t [8][5];
    t = '{'{8'h8b, 8'h7f, 8'h7f, 8'h00, 8'hd0}, '{8'h8b, 8'h01, 8'h80, 8'h00, 8'hfa},
      '{8'hcb, 8'hff, 8'h80, 8'hff, 8'hd8}, '{8'h1b, 8'h00, 8'h7f, 8'hff, 8'hd3},
      '{8'h89, 8'h00, 8'h80, 8'hff, 8'hfa}, '{8'hc9, 8'hff, 8'h80, 8'hfe, 8'hf9},
      '{8'h8b, 8'h80, 8'h00, 8'hfe, 8'hd7}, '{8'hc9, 8'h01, 8'h00, 8'h00, 8'hf5}};
    pc = 16'h0001;
    for (int i = 0; i < 8; i++) begin
      put(t[i][0]);
      if (t[i][0] != 8'h1b) put(t[i][1]);
    end
    start;
    for (int i = 0; i < 8; i++) begin
      step(2, (t[i][0] == 8'h1b) ? 1 : 2);
      check({8'h00, accumulator_a}, {8'h00, t[i][2]});
      check({8'h00, accumulator_b}, {8'h00, t[i][3]});
      check({8'h00, condition_flags_register}, {8'h00, t[i][4]});
    end
  endtask
  // b added into both index registers across the byte carry, then indexed reads
  task index_adds;
    logic [7:0] p [12];
    p = '{8'hcb, 8'hff, 8'h3a, 8'h3a, 8'h18, 8'h3a, 8'h18, 8'h3a, 8'hab, 8'h10, 8'h18, 8'heb};
    pc = 16'h0001;
    foreach (p[i]) put(p[i]);
    put(8'h02);
    mem.ram[16'h020e] = 8'h03;
    mem.ram[16'h0200] = 8'h04;
    start;
    step(2, 2);
    step(3, 1);
    check(index_x, 16'h00ff);
    step(3, 1);
    check(index_x, 16'h01fe);
    step(4, 2);
    check(index_y, 16'h00ff);
    step(4, 2);
    check(index_y, 16'h01fe);
    check({8'h00, accumulator_b}, 16'h00ff);
    check({8'h00, condition_flags_register}, 16'h00d8);
    step(4, 2);
    check({8'h00, accumulator_a}, 16'h0003);
    step(5, 3);
    check({8'h00, accumulator_b}, 16'h0003);
  endtask
  // main sequence
  initial begin
    for (int i = 0; i < 65536; i++) mem.ram[i] = 8'h01;
    all_codes;
    flag_table;
    index_adds;
    stop_test;
  end
endmodule // cpu_add_instruction_group_tb
